// *** rtl/i2m_master.sv ***
// APB-attached I2C bus master with arbitration and clock synchronisation.
//
// Decided for this implementation: the APB register port.
`timescale 1ns/1ps
`include "i2m_consts.svh"
module i2m_master
  import i2m_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic scl_in,
  output logic scl_out,
  output logic scl_oe,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  output logic done_irq
);
  i2m_state_type state_q;
  i2m_mode_type mode_q;
  i2m_act_type act;
  logic [1:0] ph_q;
  logic [2:0] bit_q;
  logic [7:0] sh_q;
  logic [7:0] rx_q;
  logic [7:0] tx_q;
  logic [7:0] addr_q;
  logic [7:0] div_q;
  logic scl_oe_q;
  logic sda_oe_q;
  logic pin_lo_q;
  logic done_q;
  logic filt_q;
  logic ack_q;
  logic stop_q;
  logic rs_op_q;
  logic clear_q;
  logic arb_q;
  logic dnack_q;
  logic anack_q;
  logic err_q;
  logic line_occ_q;
  logic scl_p_q;
  logic sda_p_q;
  logic toen_q;
  logic tof_q;
  logic [6:0] toset_q;
  logic [9:0] tq_q;
  logic [10:0] tmo_q;
  logic pready_q;
  logic pslverr_q;
  logic [31:0] prdata_q;
  logic access;
  logic wr_fire;
  logic bit_state;
  logic wait_hi;
  logic adv;
  logic samp;
  logic cmd_hit;
  logic cmd_go;
  logic arb_busy;
  logic arb_hit;
  logic nack_hit;
  logic tmo_hit;
  logic mapped;
  logic [7:0] rd_byte;

  i2m_lines_if lines ();

  i2m_line_filter u_filt (
    .pclk(pclk),
    .presetn(presetn),
    .scl_in(scl_in),
    .sda_in(sda_in),
    .lines(lines)
  );

  i2m_tick_gen u_tick (
    .pclk(pclk),
    .presetn(presetn),
    .lines(lines)
  );

  function automatic logic reg_sel(input logic [11:0] a,
                                   input logic [9:0] idx);
    reg_sel = (a[11:2] == idx) && (a[1:0] == 2'h0);
  endfunction : reg_sel

  // Only the permitted combinations for the present mode start anything.
  function automatic i2m_act_type decode(input i2m_mode_type m,
                                         input logic rs,
                                         input logic [31:0] w);
    decode = ACT_NOP;
    if (!w[`I2M_C_HS]) begin
      if (w[`I2M_C_START] && w[`I2M_C_RUN]) begin
        if (!(rs && w[`I2M_C_ACK] && w[`I2M_C_STOP])) begin
          decode = ACT_START;
        end
      end else if (m != MODE_NONE && !w[`I2M_C_START]) begin
        if (w[`I2M_C_RUN]) begin
          if (!(m == MODE_RX && w[`I2M_C_ACK] && w[`I2M_C_STOP])) begin
            decode = ACT_RUN;
          end
        end else if (w[`I2M_C_STOP]) begin
          decode = ACT_STOP;
        end
      end
    end
  endfunction : decode

  assign access = psel && penable && !pready_q;
  assign wr_fire = psel && penable && pready_q && pwrite;
  assign bit_state = state_q != ST_IDLE && state_q != ST_HOLD;
  // SCL released but still held low by a slave or another master.
  assign wait_hi = bit_state && ph_q == 2'h2 && !lines.scl_f;
  // A low SCL during our second high quarter cuts that phase short.
  assign adv = bit_state && ((lines.tick && !wait_hi) ||
    (ph_q == 2'h3 && !lines.scl_f));
  assign samp = adv && ph_q == 2'h2;
  assign act = decode(mode_q, addr_q[0], pwdata);
  assign cmd_hit = wr_fire && reg_sel(paddr, `I2M_IDX_CTRL) &&
    !pwdata[`I2M_C_CLEAR] && !bit_state && act != ACT_NOP;
  assign arb_busy = cmd_hit && act == ACT_START && mode_q == MODE_NONE &&
    line_occ_q;
  assign cmd_go = cmd_hit && !arb_busy;
  assign arb_hit = samp && (state_q == ST_ADDR || state_q == ST_TX) &&
    !sda_oe_q && !lines.sda_f;
  assign nack_hit = samp && lines.sda_f &&
    (state_q == ST_ADDR_ACK || state_q == ST_TX_ACK);
  assign tmo_hit = wait_hi && toen_q &&
    tmo_q == {1'b0, toset_q, 3'h0} + `I2M_TMO_UNIT;

  assign lines.period = div_q;
  assign lines.filt_en = filt_q;
  assign lines.restart = wait_hi || cmd_go;

  // Bit sequencer: each bit is four quarters, SCL low for the first two.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= ST_IDLE;
      mode_q <= MODE_NONE;
      ph_q <= 2'h0;
      bit_q <= 3'h0;
      sh_q <= `I2M_RST_BYTE;
      rx_q <= `I2M_RST_BYTE;
      scl_oe_q <= 1'b0;
      sda_oe_q <= 1'b0;
      done_q <= 1'b0;
      ack_q <= 1'b0;
      stop_q <= 1'b0;
      rs_op_q <= 1'b0;
    end else begin
      done_q <= 1'b0;
      if (clear_q || tmo_hit) begin
        state_q <= ST_IDLE;
        mode_q <= MODE_NONE;
        ph_q <= 2'h0;
        scl_oe_q <= 1'b0;
        sda_oe_q <= 1'b0;
        done_q <= tmo_hit;
      end else if (cmd_go) begin
        ph_q <= 2'h0;
        bit_q <= 3'h0;
        stop_q <= pwdata[`I2M_C_STOP];
        ack_q <= pwdata[`I2M_C_ACK];
        if (act == ACT_START) begin
          state_q <= ST_START;
          rs_op_q <= addr_q[0];
        end else if (act == ACT_RUN) begin
          state_q <= (mode_q == MODE_RX) ? ST_RX : ST_TX;
          sh_q <= tx_q;
        end else begin
          state_q <= ST_STOP;
        end
      end else if (arb_busy || arb_hit) begin
        // Losing arbitration frees both lines at once for the winner.
        state_q <= ST_IDLE;
        mode_q <= MODE_NONE;
        ph_q <= 2'h0;
        scl_oe_q <= 1'b0;
        sda_oe_q <= 1'b0;
        done_q <= 1'b1;
      end else if (adv) begin
        ph_q <= ph_q + 2'h1;
        unique case (ph_q)
          2'h0: begin
            if (state_q == ST_START) begin
              sda_oe_q <= 1'b0;
            end else if (state_q == ST_STOP) begin
              sda_oe_q <= 1'b1;
            end else if (state_q == ST_ADDR || state_q == ST_TX) begin
              sda_oe_q <= !sh_q[7];
            end else if (state_q == ST_RX_ACK) begin
              sda_oe_q <= ack_q;
            end else begin
              sda_oe_q <= 1'b0;
            end
          end
          2'h1: begin
            scl_oe_q <= 1'b0;
          end
          2'h2: begin
            if (state_q == ST_START) begin
              sda_oe_q <= 1'b1;
            end else if (state_q == ST_STOP) begin
              sda_oe_q <= 1'b0;
            end else if (state_q == ST_RX) begin
              sh_q <= {sh_q[6:0], lines.sda_f};
            end
          end
          2'h3: begin
            scl_oe_q <= 1'b1;
            unique case (state_q)
              ST_START: begin
                state_q <= ST_ADDR;
                sh_q <= {addr_q[7:1], rs_op_q};
                bit_q <= 3'h0;
              end
              ST_ADDR, ST_TX: begin
                sh_q <= {sh_q[6:0], 1'b0};
                bit_q <= bit_q + 3'h1;
                if (bit_q == 3'h7) begin
                  state_q <= (state_q == ST_ADDR) ? ST_ADDR_ACK : ST_TX_ACK;
                end
              end
              ST_RX: begin
                bit_q <= bit_q + 3'h1;
                if (bit_q == 3'h7) begin
                  state_q <= ST_RX_ACK;
                  rx_q <= sh_q;
                end
              end
              ST_ADDR_ACK: begin
                bit_q <= 3'h0;
                if (anack_q) begin
                  state_q <= ST_STOP;
                end else if (rs_op_q) begin
                  state_q <= ST_RX;
                  mode_q <= MODE_RX;
                end else begin
                  state_q <= ST_TX;
                  mode_q <= MODE_TX;
                  sh_q <= tx_q;
                end
              end
              ST_TX_ACK, ST_RX_ACK: begin
                if (dnack_q || stop_q) begin
                  state_q <= ST_STOP;
                end else begin
                  // Hold SCL low between bytes of a burst.
                  state_q <= ST_HOLD;
                  sda_oe_q <= 1'b0;
                  done_q <= 1'b1;
                end
              end
              ST_STOP: begin
                state_q <= ST_IDLE;
                mode_q <= MODE_NONE;
                scl_oe_q <= 1'b0;
                done_q <= 1'b1;
              end
              ST_IDLE, ST_HOLD: begin
                state_q <= state_q;
              end
            endcase
          end
        endcase
      end
    end
  end

  // Result flags of the last command; a new command clears them.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      arb_q <= 1'b0;
      dnack_q <= 1'b0;
      anack_q <= 1'b0;
      err_q <= 1'b0;
    end else begin
      if (clear_q || cmd_hit) begin
        arb_q <= arb_busy;
        err_q <= arb_busy;
        dnack_q <= 1'b0;
        anack_q <= 1'b0;
      end
      if (arb_hit) begin
        arb_q <= 1'b1;
        err_q <= 1'b1;
      end
      if (nack_hit && state_q == ST_ADDR_ACK) begin
        anack_q <= 1'b1;
        err_q <= 1'b1;
      end
      if (nack_hit && state_q == ST_TX_ACK) begin
        dnack_q <= 1'b1;
        err_q <= 1'b1;
      end
    end
  end

  // Start and stop are seen on the lines whoever drives them.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      scl_p_q <= 1'b1;
      sda_p_q <= 1'b1;
      line_occ_q <= 1'b0;
    end else begin
      scl_p_q <= lines.scl_f;
      sda_p_q <= lines.sda_f;
      if (lines.scl_f && scl_p_q && sda_p_q && !lines.sda_f) begin
        line_occ_q <= 1'b1;
      end else if (lines.scl_f && scl_p_q && !sda_p_q && lines.sda_f) begin
        line_occ_q <= 1'b0;
      end
    end
  end

  // Timeout counts quarter periods while SCL is held low against us.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tq_q <= 10'h000;
      tmo_q <= 11'h000;
      tof_q <= 1'b0;
    end else begin
      if (clear_q) begin
        tof_q <= 1'b0;
      end
      // An expiry in the cycle of a clear still leaves the flag set.
      if (tmo_hit) begin
        tof_q <= 1'b1;
      end
      if (!wait_hi || !toen_q || clear_q) begin
        tq_q <= 10'h000;
        tmo_q <= 11'h000;
      end else if (tq_q >= quarter_len(div_q) - 10'h001) begin
        tq_q <= 10'h000;
        tmo_q <= tmo_q + 11'h001;
      end else begin
        tq_q <= tq_q + 10'h001;
      end
    end
  end

  // Software-written registers; writes land on the completing APB edge.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      addr_q <= `I2M_RST_BYTE;
      tx_q <= `I2M_RST_BYTE;
      div_q <= `I2M_RST_BYTE;
      filt_q <= 1'b0;
      toen_q <= 1'b0;
      toset_q <= 7'h00;
      clear_q <= 1'b0;
    end else begin
      clear_q <= wr_fire && reg_sel(paddr, `I2M_IDX_CTRL) &&
        pwdata[`I2M_C_CLEAR];
      if (wr_fire) begin
        if (reg_sel(paddr, `I2M_IDX_ADDR)) begin
          addr_q <= pwdata[7:0];
        end
        if (reg_sel(paddr, `I2M_IDX_BUF)) begin
          tx_q <= pwdata[7:0];
        end
        if (reg_sel(paddr, `I2M_IDX_DIV)) begin
          div_q <= pwdata[7:0];
        end
        if (reg_sel(paddr, `I2M_IDX_CTRL)) begin
          filt_q <= pwdata[`I2M_C_FILT];
        end
        if (reg_sel(paddr, `I2M_IDX_TMO)) begin
          toen_q <= pwdata[`I2M_TMO_EN];
          toset_q <= pwdata[6:0];
        end
      end
    end
  end

  always_comb begin
    mapped = 1'b1;
    rd_byte = `I2M_RST_BYTE;
    if (reg_sel(paddr, `I2M_IDX_ADDR)) begin
      rd_byte = addr_q;
    end else if (reg_sel(paddr, `I2M_IDX_CTRL)) begin
      rd_byte = {1'b0, line_occ_q, state_q == ST_IDLE, arb_q, dnack_q,
        anack_q, err_q, bit_state};
    end else if (reg_sel(paddr, `I2M_IDX_BUF)) begin
      rd_byte = rx_q;
    end else if (reg_sel(paddr, `I2M_IDX_DIV)) begin
      rd_byte = div_q;
    end else if (reg_sel(paddr, `I2M_IDX_TMO)) begin
      rd_byte = {tof_q, toset_q};
    end else begin
      mapped = 1'b0;
    end
  end

  // One wait state: read data is captured on the first access edge.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h0000_0000;
      pin_lo_q <= 1'b0;
    end else begin
      pready_q <= access;
      pslverr_q <= access && !mapped;
      pin_lo_q <= 1'b0;
      if (access) begin
        prdata_q <= {24'h00_0000, rd_byte};
      end
    end
  end

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign scl_out = pin_lo_q;
  assign sda_out = pin_lo_q;
  assign scl_oe = scl_oe_q;
  assign sda_oe = sda_oe_q;
  assign done_irq = done_q;
endmodule : i2m_master

// *** rtl/i2m_consts.svh ***
// Register map, field positions and timing constants of the I2C master.
// Operation
// - Arbitrate and synchronise SCL so other masters can share the bus.
// - SCL rate never exceeds one twelfth of the system clock.
// - Divider 1..255 gives clock/8/(n+1); zero gives clock/12.
// - Address register holds 7-bit target above direction bit; one means receive.
// - Written data byte is sent by the next send, MSB first.
// - Reading the buffer returns the last received byte, apart from transmit.
// - Clear bit resets the state machine and drops back to zero itself.
// - Filter enable suppresses pulses under 50 ns on SCL and SDA.
// - Idle status bit shows the state machine is idle.
// - Busy status bit is set while receiving or transmitting.
// - Bus busy set by any start condition, cleared by any stop.
// - Error bit set on address nack, data nack or lost arbitration.
// - Address nack bit set when the address got no acknowledge.
// - Data nack bit set when a sent data byte got no acknowledge.
// - Arbitration lost bit set when arbitration was lost.
// - Control register is a command port on write, status on read.
// - Start bit makes a (repeated) start; stop bit ends or bursts.
// - Interrupt on completion of a command and on an error abort.
// - With ack set every received byte is acked; clear before last.
// - Timeout is (setting+1) times two bit periods; sets flag and interrupt.
// - Command combinations not listed as permitted do nothing.
`ifndef I2M_CONSTS_SVH
`define I2M_CONSTS_SVH
`define I2M_IDX_ADDR 10'h0f4
`define I2M_IDX_CTRL 10'h0f5
`define I2M_IDX_BUF 10'h0f6
`define I2M_IDX_DIV 10'h0f7
`define I2M_IDX_TMO 10'h0c3
`define I2M_RST_BYTE 8'h00
`define I2M_CLK_MHZ 20
`define I2M_FILT_NS 50
`define I2M_FILT_CYC ((`I2M_FILT_NS * `I2M_CLK_MHZ + 999) / 1000)
`define I2M_QTR_MIN 10'h003
`define I2M_QTR_STEP 10'h002
`define I2M_TMO_UNIT 11'h008
`define I2M_C_CLEAR 7
`define I2M_C_FILT 6
`define I2M_C_HS 4
`define I2M_C_ACK 3
`define I2M_C_STOP 2
`define I2M_C_START 1
`define I2M_C_RUN 0
`define I2M_TMO_EN 7
`endif

// *** rtl/i2m_pkg.sv ***
// Types and shared timing function of the I2C master.
`include "i2m_consts.svh"
package i2m_pkg;
  typedef enum logic [3:0] {ST_IDLE, ST_START, ST_ADDR, ST_ADDR_ACK, ST_TX,
    ST_TX_ACK, ST_RX, ST_RX_ACK, ST_STOP, ST_HOLD} i2m_state_type;
  typedef enum logic [1:0] {MODE_NONE, MODE_TX, MODE_RX} i2m_mode_type;
  typedef enum logic [1:0] {ACT_NOP, ACT_START, ACT_RUN, ACT_STOP} i2m_act_type;

  // A bit is four quarters: 2*(p+1) clocks each, or 3 when p is zero.
  function automatic logic [9:0] quarter_len(input logic [7:0] p);
    quarter_len = (p == 8'h00) ? `I2M_QTR_MIN :
      {1'b0, p, 1'b0} + `I2M_QTR_STEP;
  endfunction : quarter_len
endpackage : i2m_pkg

// *** rtl/i2m_lines_if.sv ***
// Timing tick and filtered bus lines shared inside the I2C master.
`timescale 1ns/1ps
interface i2m_lines_if;
  logic [7:0] period;
  logic restart;
  logic tick;
  logic filt_en;
  logic scl_f;
  logic sda_f;
  modport tick_gen (input period, input restart, output tick);
  modport filt (input filt_en, output scl_f, output sda_f);
  modport core (output period, output restart, input tick,
    output filt_en, input scl_f, input sda_f);
endinterface : i2m_lines_if

// *** rtl/i2m_line_filter.sv ***
// Synchroniser and glitch filter for the SCL and SDA inputs.
`timescale 1ns/1ps
`include "i2m_consts.svh"
module i2m_line_filter (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic scl_in,
  input wire logic sda_in,
  i2m_lines_if.filt lines
);
  logic [1:0] meta_q;
  logic [1:0] sync_q;
  logic [1:0] line_q;
  logic [1:0] cnt_q [2];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_q <= 2'h3;
      sync_q <= 2'h3;
    end else begin
      meta_q <= {scl_in, sda_in};
      sync_q <= meta_q;
    end
  end

  // A change must persist on consecutive samples, so a pulse shorter than
  // the filter time is never passed on.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      line_q <= 2'h3;
      cnt_q[0] <= 2'h0;
      cnt_q[1] <= 2'h0;
    end else begin
      for (int i = 0; i < 2; i++) begin
        if (sync_q[i] == line_q[i]) begin
          cnt_q[i] <= 2'h0;
        end else if (!lines.filt_en ||
            cnt_q[i] == 2'(`I2M_FILT_CYC)) begin
          line_q[i] <= sync_q[i];
          cnt_q[i] <= 2'h0;
        end else begin
          cnt_q[i] <= cnt_q[i] + 2'h1;
        end
      end
    end
  end

  assign lines.scl_f = line_q[1];
  assign lines.sda_f = line_q[0];
endmodule : i2m_line_filter

// *** rtl/i2m_tick_gen.sv ***
// Quarter-bit tick generator for the I2C master.
`timescale 1ns/1ps
module i2m_tick_gen
  import i2m_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  i2m_lines_if.tick_gen lines
);
  logic [9:0] cnt_q;
  logic tick_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q <= 10'h000;
      tick_q <= 1'b0;
    end else if (lines.restart) begin
      cnt_q <= 10'h000;
      tick_q <= 1'b0;
    end else if (cnt_q >= quarter_len(lines.period) - 10'h001) begin
      cnt_q <= 10'h000;
      tick_q <= 1'b1;
    end else begin
      cnt_q <= cnt_q + 10'h001;
      tick_q <= 1'b0;
    end
  end

  assign lines.tick = tick_q;
endmodule : i2m_tick_gen

// *** testbench/i2m_master_assertions.sv ***
// Concurrent checks on the ports of the I2C master.
`timescale 1ns/1ps
`include "i2m_consts.svh"
module i2m_master_assertions (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic scl_in,
  input wire logic scl_out,
  input wire logic scl_oe,
  input wire logic sda_in,
  input wire logic sda_out,
  input wire logic sda_oe,
  input wire logic done_irq
);
  logic mapped;
  assign mapped = paddr inside {{`I2M_IDX_ADDR, 2'b00}, {`I2M_IDX_CTRL, 2'b00},
    {`I2M_IDX_BUF, 2'b00}, {`I2M_IDX_DIV, 2'b00}, {`I2M_IDX_TMO, 2'b00}};
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  sequence s_wait;
    psel && penable && !pready;
  endsequence
  // Two quarters of at least three clocks each keep SCL low.
  sequence s_low;
    scl_oe [*6];
  endsequence
  sequence s_high;
    !scl_oe [*4];
  endsequence
  chk_ready_wait: assert property (s_wait |=> pready)
    else $error("pready late after access phase");
  chk_ready_pulse: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  chk_map_err: assert property (pready |-> pslverr == !mapped)
    else $error("pslverr does not match address map");
  chk_read_width: assert property (pready && !pwrite |->
    prdata[31:8] == 24'h0 && !(pslverr && prdata[7:0] != 8'h00))
    else $error("read data outside one byte");
  chk_open_drain: assert property (!scl_out && !sda_out)
    else $error("line driven high");
  chk_irq_pulse: assert property (done_irq |=> !done_irq)
    else $error("done pulse too long");
  chk_scl_low: assert property ($rose(scl_oe) |-> s_low)
    else $error("SCL low phase too short");
  chk_scl_high: assert property ($fell(scl_oe) |-> s_high)
    else $error("SCL high phase too short");
endmodule : i2m_master_assertions

bind i2m_master i2m_master_assertions i_chk (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .scl_in(scl_in), .scl_out(scl_out), .scl_oe(scl_oe), .sda_in(sda_in),
  .sda_out(sda_out), .sda_oe(sda_oe), .done_irq(done_irq));

// *** testbench/i2m_slave_model.sv ***
// Behavioural I2C slave that answers the master under test.
`timescale 1ns/1ps
module i2m_slave_model #(parameter logic [6:0] DEV = 7'h2a) (
  input wire logic pclk,
  input wire logic scl,
  input wire logic sda,
  input wire logic [7:0] tx_byte,
  input wire logic [7:0] stretch_len,
  input wire logic nack_data,
  output logic sda_pull,
  output logic scl_pull,
  output logic [7:0] rx_byte,
  output logic got_stop
);
  logic scl_q = 1'b1;
  logic sda_q = 1'b1;
  logic first = 1'b0;
  logic sel = 1'b0;
  logic rd = 1'b0;
  logic [3:0] cnt = 4'h0;
  logic [7:0] sh = 8'h00;
  logic [7:0] tq = 8'h00;
  logic [7:0] st = 8'h00;
  initial begin
    sda_pull = 1'b0;
    scl_pull = 1'b0;
    rx_byte = 8'h00;
    got_stop = 1'b0;
  end
  always @(posedge pclk) begin
    scl_q <= scl;
    sda_q <= sda;
    if (st != 8'h00) begin
      st <= st - 8'h01;
      scl_pull <= (st != 8'h01);
    end
    if (scl && scl_q && sda_q && !sda) begin
      cnt <= 4'h0;
      first <= 1'b1;
      got_stop <= 1'b0;
    end else if (scl && scl_q && !sda_q && sda) begin
      got_stop <= 1'b1;
      sel <= 1'b0;
    end else if (scl && !scl_q) begin
      sh <= (cnt < 4'h8) ? {sh[6:0], sda} : sh;
      // A master nack on a read byte ends our turn on the data line.
      if (cnt == 4'h8 && rd && sda)
        sel <= 1'b0;
      cnt <= cnt + 4'h1;
    end else if (!scl && scl_q) begin
      if (cnt == 4'h8 && first) begin
        sel <= (sh[7:1] == DEV);
        rd <= sh[0];
        sda_pull <= (sh[7:1] == DEV);
      end else if (cnt == 4'h8) begin
        if (sel && !rd)
          rx_byte <= sh;
        sda_pull <= sel && !rd && !nack_data;
      end else if (cnt == 4'h9) begin
        cnt <= 4'h0;
        first <= 1'b0;
        tq <= {tx_byte[6:0], 1'b0};
        sda_pull <= sel && rd && !tx_byte[7];
        st <= sel ? stretch_len : 8'h00;
        scl_pull <= sel && (stretch_len != 8'h00);
      end else if (sel && rd && !first) begin
        sda_pull <= !tq[7];
        tq <= {tq[6:0], 1'b0};
      end
    end
  end
endmodule : i2m_slave_model

// *** testbench/i2c_bus_master_controller_tb_top.sv ***
// Self-checking bench for the I2C master with a slave model on the bus.
`timescale 1ns/1ps
`include "i2m_consts.svh"
module i2c_bus_master_controller_tb_top;
  localparam logic [6:0] DEV = 7'h2a;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready, pslverr, scl_out, scl_oe, sda_out, sda_oe, done_irq;
  logic sda_pull, scl_pull, got_stop, rival = 1'b0, nack_data = 1'b0;
  logic done_seen = 1'b0;
  logic scl_d = 1'b1;
  logic [7:0] rx_byte, tx_byte = 8'h00, stretch_len = 8'h00;
  int num_errors = 0, comparisons = 0, cyc = 0, since = 0, min_per = 255;
  wire scl = !(scl_oe || scl_pull);
  wire sda = !(sda_oe || sda_pull || rival);
  always #25 pclk = ~pclk;
  i2m_master i_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .scl_in(scl),
    .scl_out(scl_out), .scl_oe(scl_oe), .sda_in(sda), .sda_out(sda_out),
    .sda_oe(sda_oe), .done_irq(done_irq));
  i2m_slave_model #(.DEV(DEV)) i_slave (.pclk(pclk), .scl(scl), .sda(sda),
    .tx_byte(tx_byte), .stretch_len(stretch_len), .nack_data(nack_data),
    .sda_pull(sda_pull), .scl_pull(scl_pull), .rx_byte(rx_byte),
    .got_stop(got_stop));
  // The ceiling is several times the longest expected run.
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    scl_d <= scl;
    since <= (scl && !scl_d) ? 0 : since + 1;
    if (scl && !scl_d && since + 1 < min_per)
      min_per <= since + 1;
    if (done_irq === 1'b1)
      done_seen <= 1'b1;
    if (cyc == 40000) begin
      num_errors++;
      close_out();
    end
  end
  task automatic close_out();
    if (num_errors == 0 && comparisons > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : close_out
  task automatic check_eq(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask : check_eq
  task automatic apb(input logic wr, input logic [9:0] idx,
      input logic [7:0] wd, output logic [31:0] r, output logic e);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= {idx, 2'b00};
    pwdata <= {24'h000000, wd};
    @(posedge pclk);
    penable <= 1'b1;
    do
      @(posedge pclk);
    while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb
  task automatic wr(input logic [9:0] idx, input logic [7:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, idx, d, r, e);
  endtask : wr
  task automatic rd_chk(input logic [9:0] idx, input logic [7:0] exp,
      input logic [7:0] m = 8'hff);
    logic [31:0] r;
    logic e;
    apb(1'b0, idx, 8'h00, r, e);
    check_eq(r & {24'h0, m}, {24'h0, exp & m});
  endtask : rd_chk
  task automatic wait_done(input logic exp);
    int n;
    for (n = 0; n < 1000 && !done_seen; n++)
      @(posedge pclk);
    check_eq(done_seen, exp);
  endtask : wait_done
  // The high-speed bit stays clear in every legal command.
  task automatic cmd(input logic [7:0] sa, input logic [7:0] ctl);
    wr(`I2M_IDX_ADDR, sa);
    done_seen = 1'b0;
    min_per = 255;
    wr(`I2M_IDX_CTRL, ctl);
    wait_done(1'b1);
  endtask : cmd
  task automatic t_regs();
    logic [31:0] r;
    logic e;
    rd_chk(`I2M_IDX_ADDR, 8'h00);
    rd_chk(`I2M_IDX_BUF, 8'h00);
    rd_chk(`I2M_IDX_DIV, 8'h00);
    rd_chk(`I2M_IDX_CTRL, 8'h20);
    apb(1'b0, 10'h001, 8'h00, r, e);
    check_eq(e, 1'b1);
    wr(`I2M_IDX_ADDR, 8'ha5);
    rd_chk(`I2M_IDX_ADDR, 8'ha5);
  endtask : t_regs
  task automatic t_send();
    wr(`I2M_IDX_DIV, 8'h01);
    rd_chk(`I2M_IDX_DIV, 8'h01);
    wr(`I2M_IDX_BUF, 8'hc3);
    cmd({DEV, 1'b0}, 8'h07);
    check_eq(rx_byte, 8'hc3);
    check_eq(got_stop, 1'b1);
    check_eq(min_per >= 16 && min_per <= 20, 1'b1);
    rd_chk(`I2M_IDX_CTRL, 8'h20);
  endtask : t_send
  task automatic t_recv();
    wr(`I2M_IDX_DIV, 8'h00);
    tx_byte <= 8'h96;
    stretch_len <= 8'h14;
    cmd({DEV, 1'b1}, 8'h07);
    rd_chk(`I2M_IDX_BUF, 8'h96);
    check_eq(min_per >= 12, 1'b1);
  endtask : t_recv
  task automatic t_nack();
    cmd({7'h11, 1'b0}, 8'h07);
    rd_chk(`I2M_IDX_CTRL, 8'h26);
    nack_data <= 1'b1;
    cmd({DEV, 1'b0}, 8'h07);
    rd_chk(`I2M_IDX_CTRL, 8'h2a);
    nack_data <= 1'b0;
  endtask : t_nack
  task automatic t_arb();
    rival <= 1'b1;
    repeat (4) @(posedge pclk);
    rd_chk(`I2M_IDX_CTRL, 8'h6a);
    cmd({DEV, 1'b0}, 8'h03);
    rd_chk(`I2M_IDX_CTRL, 8'h72);
    rival <= 1'b0;
    // Allow for the synchroniser and filter on the data line.
    repeat (4) @(posedge pclk);
    rd_chk(`I2M_IDX_CTRL, 8'h32);
  endtask : t_arb
  task automatic t_nop();
    logic [7:0] ctl [4] = '{8'h0f, 8'h13, 8'h01, 8'h04};
    wr(`I2M_IDX_ADDR, {DEV, 1'b1});
    foreach (ctl[i]) begin
      done_seen = 1'b0;
      wr(`I2M_IDX_CTRL, ctl[i]);
      wait_done(1'b0);
    end
  endtask : t_nop
  task automatic t_timeout();
    wr(`I2M_IDX_TMO, 8'h80);
    stretch_len <= 8'hfa;
    wr(`I2M_IDX_ADDR, {DEV, 1'b0});
    done_seen = 1'b0;
    wr(`I2M_IDX_CTRL, 8'h03);
    rd_chk(`I2M_IDX_CTRL, 8'h01, 8'h21);
    wait_done(1'b1);
    rd_chk(`I2M_IDX_TMO, 8'h80);
    wr(`I2M_IDX_CTRL, 8'h80);
    rd_chk(`I2M_IDX_TMO, 8'h00);
    rd_chk(`I2M_IDX_CTRL, 8'h20, 8'hb1);
  endtask : t_timeout
  initial begin
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_regs();
    t_send();
    t_recv();
    t_nack();
    t_arb();
    t_nop();
    t_timeout();
    close_out();
  end
endmodule : i2c_bus_master_controller_tb_top
